// ==== rtl/sscw_cfg.svh ====
// Functional notes
// (RQ1) configuration only via serial clock, data and strobe lines driven by host
// (RQ2) every transfer carries 19 bits: word select plus 18 data bits
// (RQ3) bits arrive most significant first, bit 18 first, word select last
// (RQ4) bit 0 zero writes current word; bit 0 one targets timing word
// (RQ5) bits 1..6 form bridge one DAC code, bit 1 least significant
// (RQ6) bits 7..12 form bridge two DAC code, bit 7 least significant
// (RQ7) zero DAC code disables that bridge, all four drivers off
// (RQ8) bit 13 sets bridge one direction: 0 gives A low B high
// (RQ9) bit 14 sets bridge two direction: 0 gives A low B high
// (RQ10) bits 15 and 16 pick decay: 0 mixed, 1 slow
// (RQ11) bit 17 picks DAC reference: 0 internal 2 V, 1 external
// (RQ12) bit 18 picks sense range: 0 divide by 8, 1 divide by 4
// (RQ13) sleep low clears all stored serial bits and disables circuits
// (RQ14) power-up or logic undervoltage clears serial data and disables drivers
// (RQ15) data sampled on serial clock rise; strobe after last bit loads word
// (RQ16) timing word transfer leaves current word fields unchanged
`ifndef SSCW_CFG_SVH
`define SSCW_CFG_SVH
`define SSCW_WORD_BITS   19
`define SSCW_SEL_POS     0
`define SSCW_DAC1_LSB    1
`define SSCW_DAC2_LSB    7
`define SSCW_DAC_BITS    6
`define SSCW_PH1_POS     13
`define SSCW_PH2_POS     14
`define SSCW_MODE1_POS   15
`define SSCW_MODE2_POS   16
`define SSCW_REF_POS     17
`define SSCW_RANGE_POS   18
`define SSCW_WORD_RESET  19'h00000
`endif

// ==== rtl/sscw_pkg.sv ====
package sscw_pkg;
  typedef logic [18:0] sscw_word_t;
  typedef logic [5:0]  sscw_dac_t;
  typedef enum logic { SSCW_DECAY_MIXED, SSCW_DECAY_SLOW } sscw_decay_t;
  typedef enum logic [1:0] { SSCW_IDLE, SSCW_SHIFT } sscw_state_t;
endpackage

// ==== rtl/sscw_bridge_if.sv ====
`timescale 1ns/1ps
interface sscw_bridge_if;
  logic [5:0] dac;
  logic       phase;
  logic       out_a;
  logic       out_b;
  logic       enable;
  modport ctrl (output dac, output phase, input out_a, input out_b,
                input enable);
  modport drv  (input dac, input phase, output out_a, output out_b,
                output enable);
endinterface

// ==== rtl/sscw_bridge.sv ====
`timescale 1ns/1ps
module sscw_bridge
  import sscw_pkg::*;
(
  sscw_bridge_if.drv br
);
  // ********************************************************
  // bridge direction and disable decode
  // ********************************************************
  assign br.enable = |br.dac;                         // RQ7
  assign br.out_a  = br.enable & br.phase;            // RQ8 RQ9
  assign br.out_b  = br.enable & ~br.phase;           // RQ7
endmodule

// ==== rtl/sscw_top.sv ====
`timescale 1ns/1ps
`include "sscw_cfg.svh"
module sscw_top
  import sscw_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       clk_en_i,
  input  wire logic       ser_clk_i,
  input  wire logic       ser_data_i,
  input  wire logic       ser_strobe_i,
  input  wire logic       sleepn_i,
  input  wire logic       logic_supply_undervoltage_lockout_i,
  output logic [5:0]      bridge_one_dac_o,
  output logic [5:0]      bridge_two_dac_o,
  output logic            bridge_one_output_a_o,
  output logic            bridge_one_output_b_o,
  output logic            bridge_two_output_a_o,
  output logic            bridge_two_output_b_o,
  output logic            bridge_one_enable_o,
  output logic            bridge_two_enable_o,
  output logic            bridge_one_slow_decay_o,
  output logic            bridge_two_slow_decay_o,
  output logic            ext_reference_sel_o,
  output logic            transconductance_scaling_o,
  output logic            timing_word_strobe_o,
  output logic            circuits_enable_o
);
  // ********************************************************
  // state and wires
  // ********************************************************
  logic [1:0]  sclk_s_q;     // serial clock sync pair
  logic [1:0]  sdat_s_q;     // serial data sync pair
  logic [1:0]  sstb_s_q;     // strobe sync pair
  logic [1:0]  slp_s_q;      // sleep sync pair
  logic [1:0]  uv_s_q;       // undervoltage sync pair
  logic        sclk_prev_q;
  logic        sstb_prev_q;
  sscw_word_t  shift_q;
  sscw_word_t  cur_q;
  logic [4:0]  cnt_q;
  sscw_state_t frame_q;      // idle or inside a frame
  logic        clr;
  logic        sclk_rise;
  logic        sstb_rise;
  logic        word_done;    // strobe that loads a whole word

  // ********************************************************
  // helper functions
  // ********************************************************
  // one six-bit dac code out of a stored word
  function automatic sscw_dac_t dac_field(input sscw_word_t w,
                                          input int         lsb);
    return w[lsb +: `SSCW_DAC_BITS];
  endfunction

  // decay select bit to slow-decay flag, 1 means slow
  function automatic logic is_slow(input logic b);
    return sscw_decay_t'(b) == SSCW_DECAY_SLOW;
  endfunction

  // true once exactly one full word has been shifted in
  function automatic logic full_word(input logic [4:0] c);
    return c == 5'(`SSCW_WORD_BITS);
  endfunction

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  // two flops per pin, only the second is read
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_s_q <= 2'h0;
      sdat_s_q <= 2'h0;
      sstb_s_q <= 2'h0;
      slp_s_q  <= 2'h0;
      uv_s_q   <= 2'h3;
    end else if (clk_en_i) begin
      sclk_s_q <= {sclk_s_q[0], ser_clk_i};                    // RQ1
      sdat_s_q <= {sdat_s_q[0], ser_data_i};
      sstb_s_q <= {sstb_s_q[0], ser_strobe_i};
      slp_s_q  <= {slp_s_q[0], sleepn_i};
      uv_s_q   <= {uv_s_q[0], logic_supply_undervoltage_lockout_i};
    end
  end

  // edge memory on the synchronised lines
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_prev_q <= 1'b0;
      sstb_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      sclk_prev_q <= sclk_s_q[1];
      sstb_prev_q <= sstb_s_q[1];
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_prev_q;               // RQ15
  assign sstb_rise = sstb_s_q[1] & ~sstb_prev_q;
  // sleep low or undervoltage wipes the serial port
  assign clr = ~slp_s_q[1] | uv_s_q[1];                        // RQ13 RQ14

  // ********************************************************
  // frame tracking
  // ********************************************************
  // idle until the first serial clock rise, in frame until strobe
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_q <= SSCW_IDLE;
    end else if (clk_en_i) begin
      if (clr) begin
        frame_q <= SSCW_IDLE;                                  // RQ13 RQ14
      end else begin
        case (frame_q)
          SSCW_IDLE: begin
            if (sclk_rise)
              frame_q <= SSCW_SHIFT;                           // RQ15
          end
          SSCW_SHIFT: begin
            if (sstb_rise)
              frame_q <= SSCW_IDLE;
          end
          default: frame_q <= SSCW_IDLE;
        endcase
      end
    end
  end

  // a strobe only counts after a whole word inside a frame
  assign word_done = sstb_rise && frame_q == SSCW_SHIFT &&
                     full_word(cnt_q);                         // RQ2 RQ15

  // ********************************************************
  // shift register, msb first
  // ********************************************************
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_q <= `SSCW_WORD_RESET;
      cnt_q   <= 5'h00;
    end else if (clk_en_i) begin
      if (clr) begin
        shift_q <= `SSCW_WORD_RESET;                           // RQ13
        cnt_q   <= 5'h00;
      end else if (sstb_rise) begin
        cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        shift_q <= {shift_q[17:0], sdat_s_q[1]};               // RQ3
        if (cnt_q != 5'h1F)
          cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // ********************************************************
  // command word load on strobe
  // ********************************************************
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_q                <= `SSCW_WORD_RESET;                // RQ14
      timing_word_strobe_o <= 1'b0;
    end else if (clk_en_i) begin
      timing_word_strobe_o <= 1'b0;
      if (clr) begin
        cur_q <= `SSCW_WORD_RESET;                             // RQ13 RQ14
      end else if (word_done) begin                            // RQ2
        if (!shift_q[`SSCW_SEL_POS])
          cur_q <= shift_q;                                    // RQ4 RQ15
        else
          timing_word_strobe_o <= 1'b1;                        // RQ16
      end
    end
  end

  // ********************************************************
  // field decode and bridge stages
  // ********************************************************
  sscw_bridge_if b1 ();
  sscw_bridge_if b2 ();
  assign b1.dac   = dac_field(cur_q, `SSCW_DAC1_LSB);          // RQ5
  assign b2.dac   = dac_field(cur_q, `SSCW_DAC2_LSB);          // RQ6
  assign b1.phase = cur_q[`SSCW_PH1_POS];                      // RQ8
  assign b2.phase = cur_q[`SSCW_PH2_POS];                      // RQ9
  sscw_bridge u_b1 (.br(b1));
  sscw_bridge u_b2 (.br(b2));

  // ********************************************************
  // registered bridge drive
  // ********************************************************
  // drivers and enables drop at once while the port is cleared
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bridge_one_dac_o           <= 6'h00;
      bridge_two_dac_o           <= 6'h00;
      bridge_one_output_a_o      <= 1'b0;
      bridge_one_output_b_o      <= 1'b0;
      bridge_two_output_a_o      <= 1'b0;
      bridge_two_output_b_o      <= 1'b0;
      bridge_one_enable_o        <= 1'b0;
      bridge_two_enable_o        <= 1'b0;
      circuits_enable_o          <= 1'b0;
    end else if (clk_en_i) begin
      bridge_one_dac_o           <= b1.dac;
      bridge_two_dac_o           <= b2.dac;
      bridge_one_output_a_o      <= b1.out_a & ~clr;           // RQ7 RQ8
      bridge_one_output_b_o      <= b1.out_b & ~clr;
      bridge_two_output_a_o      <= b2.out_a & ~clr;           // RQ9
      bridge_two_output_b_o      <= b2.out_b & ~clr;
      bridge_one_enable_o        <= b1.enable & ~clr;          // RQ7
      bridge_two_enable_o        <= b2.enable & ~clr;
      circuits_enable_o          <= ~clr;                      // RQ13
    end
  end

  // ********************************************************
  // registered analog settings
  // ********************************************************
  // decay, reference and range follow the stored word
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bridge_one_slow_decay_o    <= 1'b0;
      bridge_two_slow_decay_o    <= 1'b0;
      ext_reference_sel_o        <= 1'b0;
      transconductance_scaling_o <= 1'b0;
    end else if (clk_en_i) begin
      bridge_one_slow_decay_o    <= is_slow(cur_q[`SSCW_MODE1_POS]); // RQ10
      bridge_two_slow_decay_o    <= is_slow(cur_q[`SSCW_MODE2_POS]); // RQ10
      ext_reference_sel_o        <= cur_q[`SSCW_REF_POS];      // RQ11
      transconductance_scaling_o <= cur_q[`SSCW_RANGE_POS];    // RQ12
    end
  end
endmodule

// ==== bench/sscw_host_model.sv ====
`timescale 1ns/1ps
// ****************
// host serial side
// ****************
module sscw_host_model (
  input  wire logic sys_clk_i,
  output logic      ser_clk_o,
  output logic      ser_data_o,
  output logic      ser_strobe_o
);
  // serial clock stands low outside frames
  initial begin
    ser_clk_o    = 1'b0;
    ser_data_o   = 1'b0;
    ser_strobe_o = 1'b0;
  end
  // shifts n bits msb first at 64 ns, then strobes
  task automatic send(input logic [18:0] w, input int n);
    @(negedge sys_clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      ser_data_o = w[i];
      #32 ser_clk_o = 1'b1;
      #32 ser_clk_o = 1'b0;
    end
    ser_data_o = ~ser_data_o; // data no longer held
    #32 ser_strobe_o = 1'b1;
    #32 ser_strobe_o = 1'b0;
  endtask
endmodule

// ==== bench/sscw_top_props.sv ====
`timescale 1ns/1ps
// ****************
// output checks
// ****************
module sscw_top_props (
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic       sleepn_i,
  input wire logic       logic_supply_undervoltage_lockout_i,
  input wire logic [5:0] bridge_one_dac_o,
  input wire logic [5:0] bridge_two_dac_o,
  input wire logic       bridge_one_output_a_o,
  input wire logic       bridge_one_output_b_o,
  input wire logic       bridge_two_output_a_o,
  input wire logic       bridge_two_output_b_o,
  input wire logic       bridge_one_enable_o,
  input wire logic       bridge_two_enable_o,
  input wire logic       timing_word_strobe_o,
  input wire logic       circuits_enable_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // drivers follow code and enables
  a_zero_one_off: assert property (bridge_one_dac_o == 6'h00 |->
    !bridge_one_enable_o && !bridge_one_output_a_o &&
    !bridge_one_output_b_o) else $error("bridge one on at zero code");
  a_zero_two_off: assert property (bridge_two_dac_o == 6'h00 |->
    !bridge_two_enable_o && !bridge_two_output_a_o &&
    !bridge_two_output_b_o) else $error("bridge two on at zero code");
  a_one_split: assert property (bridge_one_enable_o |->
    bridge_one_output_a_o != bridge_one_output_b_o)
    else $error("bridge one sides equal");
  a_two_split: assert property (bridge_two_enable_o |->
    bridge_two_output_a_o != bridge_two_output_b_o)
    else $error("bridge two sides equal");
  a_enable_powered: assert property (
    bridge_one_enable_o || bridge_two_enable_o |-> circuits_enable_o)
    else $error("bridge on while circuits off");
  // clearing by sleep and undervoltage
  a_sleep_clears: assert property (!sleepn_i [*4] |=>
    !circuits_enable_o && bridge_one_dac_o == 6'h00 &&
    bridge_two_dac_o == 6'h00) else $error("sleep did not clear");
  a_logic_supply_undervoltage_lockout_clears: assert property (
    logic_supply_undervoltage_lockout_i [*4] |=> !circuits_enable_o &&
    bridge_one_dac_o == 6'h00) else $error("undervoltage kept data");
  a_timing_keeps: assert property (timing_word_strobe_o |=>
    ($stable(bridge_one_dac_o) && $stable(bridge_two_dac_o)) [*2])
    else $error("timing word changed current word");
  a_strobe_single: assert property (
    timing_word_strobe_o |=> !timing_word_strobe_o)
    else $error("timing strobe stood two cycles");
endmodule
bind sscw_top sscw_top_props u_sscw_top_props (.*);

// ==== bench/tb_stepper_serial_control_word.sv ====
`timescale 1ns/1ps
// ****************
// bench top
// ****************
module tb_stepper_serial_control_word;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        clk_en_i = 1'b1;
  logic        sleepn_i = 1'b1;
  logic        logic_supply_undervoltage_lockout_i = 1'b0;
  logic        ser_clk_i, ser_data_i, ser_strobe_i;
  logic [5:0]  bridge_one_dac_o, bridge_two_dac_o;
  logic        bridge_one_output_a_o, bridge_one_output_b_o;
  logic        bridge_two_output_a_o, bridge_two_output_b_o;
  logic        bridge_one_enable_o, bridge_two_enable_o;
  logic        bridge_one_slow_decay_o, bridge_two_slow_decay_o;
  logic        ext_reference_sel_o, transconductance_scaling_o;
  logic        timing_word_strobe_o, circuits_enable_o;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          strobes = 0;
  logic [18:0] cur = 19'h00000;
  logic [18:0] w;
  logic [18:0] corner [4] = '{19'h7FFFE, 19'h0007E, 19'h01F80, 19'h55554};
  wire  [22:0] obs = {bridge_one_dac_o, bridge_two_dac_o,
    bridge_one_output_a_o, bridge_one_output_b_o, bridge_two_output_a_o,
    bridge_two_output_b_o, bridge_one_enable_o, bridge_two_enable_o,
    bridge_one_slow_decay_o, bridge_two_slow_decay_o, ext_reference_sel_o,
    transconductance_scaling_o, circuits_enable_o};
  sscw_top u_sscw_top (.*);
  sscw_host_model u_sscw_host_model (.sys_clk_i(sys_clk_i),
    .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
    .ser_strobe_o(ser_strobe_i));
  // clock and hang guard
  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      report_and_stop();
    end
  end
  // timing strobe pulses, counted on the falling clock edge
  always @(negedge sys_clk_i) begin
    if (timing_word_strobe_o === 1'b1) strobes++;
  end
  // expected outputs of a current word
  function automatic logic [22:0] exp_out(input logic [18:0] x);
    logic e1, e2;
    e1 = |x[6:1];
    e2 = |x[12:7];
    return {x[6:1], x[12:7], e1 & x[13], e1 & ~x[13], e2 & x[14],
      e2 & ~x[14], e1, e2, x[15], x[16], x[17], x[18], 1'b1};
  endfunction
  task automatic chk(input string n, input logic [22:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one transfer, then compare every output
  task automatic run(input string n, input logic [18:0] x, input int nb);
    int s0;
    s0 = strobes;
    u_sscw_host_model.send(x, nb);
    if (nb == 19 && !x[0]) cur = x;
    repeat (8) @(negedge sys_clk_i);
    chk(n, obs, exp_out(cur));
    chk({n, " strobe"}, 23'(strobes - s0), 23'(nb == 19 && x[0]));
    $display("test %s done", n);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(66876));
    repeat (10) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    foreach (corner[i]) run("corner", corner[i], 19);
    repeat (6) begin
      w = 19'($urandom);
      w[0] = 1'b0;
      run("random", w, 19);
    end
    run("timing", 19'h7FFFF, 19);
    run("short", 19'h15554, 18);
    sleepn_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    chk("sleep", obs, 23'h000000);
    $display("test sleep done");
    sleepn_i = 1'b1;
    cur = 19'h00000;
    repeat (8) @(negedge sys_clk_i);
    run("after sleep", w, 19);
    resetn_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk("in reset", obs, 23'h000000);
    resetn_i = 1'b1;
    cur = 19'h00000;
    repeat (8) @(negedge sys_clk_i);
    chk("power up", obs, exp_out(cur));
    $display("test power up done");
    run("after reset", w, 19);
    clk_en_i = 1'b0;
    u_sscw_host_model.send({~w[18:1], 1'b0}, 19);
    repeat (8) @(negedge sys_clk_i);
    chk("frozen", obs, exp_out(cur));
    clk_en_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    chk("thawed", obs, exp_out(cur));
    $display("test frozen done");
    logic_supply_undervoltage_lockout_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    chk("undervoltage", obs, 23'h000000);
    $display("test undervoltage done");
    logic_supply_undervoltage_lockout_i = 1'b0;
    cur = 19'h00000;
    repeat (8) @(negedge sys_clk_i);
    chk("recovery", obs, exp_out(cur));
    $display("test recovery done");
    report_and_stop();
  end
endmodule
